// >>> rtl/sie_pkg.sv
// Constants and types for the scan master interrupt enable block
package sie_pkg;
    // Occupancy counters, in long words
    localparam int CNT_W = 7;
    typedef logic [CNT_W-1:0] sie_cnt_t;
    localparam sie_cnt_t CNT_ZERO = 7'h00;
    localparam sie_cnt_t CNT_HALF = 7'h38;
    localparam sie_cnt_t CNT_FULL = 7'h70;

    // Parallel processor port register map
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    typedef logic [ADDR_W-1:0] sie_addr_t;
    typedef logic [DATA_W-1:0] sie_word_t;
    localparam sie_addr_t ADDR_ENABLE = 8'h02;
    localparam sie_addr_t ADDR_STATUS = 8'h03;

    // Field positions, shared by enable and status words
    localparam int BIT_CAP_HEMPTY = 12;
    localparam int BIT_CAP_EMPTY  = 11;
    localparam int BIT_OUT_FULL   = 10;
    localparam int BIT_OUT_HFULL  = 9;
    localparam int BIT_SEQ        = 8;
    localparam int VEC_LSB        = 0;
    localparam int VEC_W          = 3;
    typedef logic [VEC_W-1:0] sie_vec_t;

    // Reset value and writable bits of the enable word
    localparam sie_word_t ENABLE_RESET = 16'h0000;
    localparam sie_word_t ENABLE_WMASK = 16'h1f07;
    localparam sie_word_t WORD_ZERO    = 16'h0000;

    // Vector selector codes
    localparam sie_vec_t VEC_NONE = 3'h0;
    localparam sie_vec_t VEC_MAX  = 3'h4;
endpackage

// >>> rtl/sie_cond_if.sv
// Buffer condition flags passed from detector to top
`timescale 1ns/10ps
interface sie_cond_if;
    logic cap_half_empty;
    logic cap_empty;
    logic out_full;
    logic out_half_full;

    modport det (
        output cap_half_empty,
        output cap_empty,
        output out_full,
        output out_half_full
    );
    modport use_side (
        input cap_half_empty,
        input cap_empty,
        input out_full,
        input out_half_full
    );
endinterface

// >>> rtl/sie_cond_detect.sv
// Buffer occupancy threshold detector
`timescale 1ns/10ps
module sie_cond_detect
    import sie_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_sys,
    input  wire logic      srst,
    // Occupancy counters
    input  wire sie_cnt_t  cap_count,
    input  wire sie_cnt_t  out_count,
    // Condition flags
    sie_cond_if.det        cond
);
    logic cap_half_empty;
    logic cap_empty;
    logic out_full;
    logic out_half_full;
    logic next_cap_half_empty;
    logic next_cap_empty;
    logic next_out_full;
    logic next_out_half_full;

    always_comb begin
        next_cap_half_empty = (cap_count <= CNT_HALF);
        next_cap_empty      = (cap_count == CNT_ZERO);
        next_out_full       = (out_count >= CNT_FULL);
        next_out_half_full  = (out_count >= CNT_HALF);
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cap_half_empty <= 1'b0;
            cap_empty      <= 1'b0;
            out_full       <= 1'b0;
            out_half_full  <= 1'b0;
        end else begin
            cap_half_empty <= next_cap_half_empty;
            cap_empty      <= next_cap_empty;
            out_full       <= next_out_full;
            out_half_full  <= next_out_half_full;
        end
    end

    assign cond.cap_half_empty = cap_half_empty;
    assign cond.cap_empty      = cap_empty;
    assign cond.out_full       = out_full;
    assign cond.out_half_full  = out_half_full;
endmodule

// >>> rtl/sie_top.sv
// Scan master interrupt enable register and request logic
//
// Notes on behaviour
// - The captured buffer half-empty condition interrupts only while its enable bit is 1.
// - The captured buffer empty condition interrupts only while its enable bit is 1.
// - The outgoing buffer full condition interrupts only while its enable bit is 1.
// - The outgoing buffer half-full condition interrupts only while its enable bit is 1.
// - Sequencer completion interrupts only while the sequencer enable bit is 1.
// - Half full and half empty both mean the 56 long word threshold is reached.
// - The three-bit vector enable field is read-write and resets to 000b.
// - The five reserved bits beside the vector field always read 00000b.
// - The sequencer and the four buffer enable bits are read-write and reset to 0.
// - With the sequencer enable set, a nonzero vector enable is ignored.
// - Vector enable codes 001 to 100 select vectors one to four, 000 none, above 100 reserved.
// - The sequencer status flag is 1 once processing completes, 0 while running or idle.
`timescale 1ns/10ps
module sie_top
    import sie_pkg::*;
(
    // Clock and reset
    input  wire logic      clk_sys,
    input  wire logic      srst,
    // Parallel processor port
    input  wire logic      ppp_sel,
    input  wire logic      ppp_wr,
    input  wire logic      ppp_rd,
    input  wire sie_addr_t ppp_addr,
    input  wire sie_word_t ppp_wdata,
    output sie_word_t      ppp_rdata,
    // Buffer occupancy
    input  wire sie_cnt_t  cap_count,
    input  wire sie_cnt_t  out_count,
    // Sequencer events
    input  wire logic      seq_start,
    input  wire logic      seq_done,
    input  wire sie_vec_t  vec_done,
    // Outputs
    output logic           seq_status,
    output logic           irq
);
    sie_cond_if cond ();

    sie_word_t enable;
    sie_word_t next_enable;
    sie_vec_t  vec_status;
    sie_vec_t  next_vec_status;
    logic      next_seq_status;
    sie_word_t next_ppp_rdata;
    logic      next_irq;
    sie_word_t status_word;
    sie_vec_t  en_vec;
    logic      vec_hit;
    logic      wr_en;

    sie_cond_detect i_sie_cond_detect (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .cap_count (cap_count),
        .out_count (out_count),
        .cond      (cond)
    );

    // Register access and status word
    always_comb begin
        wr_en       = ppp_sel && ppp_wr && (ppp_addr == ADDR_ENABLE);
        next_enable = enable;
        if (wr_en) begin
            next_enable = ppp_wdata & ENABLE_WMASK;
        end
        status_word                 = WORD_ZERO;
        status_word[BIT_CAP_HEMPTY] = cond.cap_half_empty;
        status_word[BIT_CAP_EMPTY]  = cond.cap_empty;
        status_word[BIT_OUT_FULL]   = cond.out_full;
        status_word[BIT_OUT_HFULL]  = cond.out_half_full;
        status_word[BIT_SEQ]        = seq_status;
        status_word[VEC_LSB +: VEC_W] = vec_status;
        next_ppp_rdata = ppp_rdata;
        if (ppp_sel && ppp_rd) begin
            if (ppp_addr == ADDR_ENABLE) begin
                next_ppp_rdata = enable;
            end else if (ppp_addr == ADDR_STATUS) begin
                next_ppp_rdata = status_word;
            end else begin
                next_ppp_rdata = WORD_ZERO;
            end
        end
    end

    // Sequencer and vector completion status
    always_comb begin
        next_seq_status = seq_status;
        next_vec_status = vec_status;
        if (seq_start) begin
            next_seq_status = 1'b0;
            next_vec_status = VEC_NONE;
        end
        if (seq_done) begin
            next_seq_status = 1'b1;
        end
        if (vec_done != VEC_NONE) begin
            next_vec_status = vec_done;
        end
    end

    // Interrupt request
    always_comb begin
        en_vec  = enable[VEC_LSB +: VEC_W];
        vec_hit = (en_vec != VEC_NONE) && (en_vec <= VEC_MAX)
                  && (vec_status == en_vec);
        next_irq = (cond.cap_half_empty && enable[BIT_CAP_HEMPTY])
                 || (cond.cap_empty && enable[BIT_CAP_EMPTY])
                 || (cond.out_full && enable[BIT_OUT_FULL])
                 || (cond.out_half_full && enable[BIT_OUT_HFULL]);
        if (enable[BIT_SEQ]) begin
            next_irq = next_irq || seq_status;
        end else begin
            next_irq = next_irq || vec_hit;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            enable     <= ENABLE_RESET;
            vec_status <= VEC_NONE;
            seq_status <= 1'b0;
            ppp_rdata  <= WORD_ZERO;
            irq        <= 1'b0;
        end else begin
            enable     <= next_enable;
            vec_status <= next_vec_status;
            seq_status <= next_seq_status;
            ppp_rdata  <= next_ppp_rdata;
            irq        <= next_irq;
        end
    end
endmodule

// >>> tb/sie_asserts.sv
// Port checker for the interrupt enable block
`timescale 1ns/10ps
module sie_asserts
    import sie_pkg::*;
(
    // Clock and reset
    input wire logic      clk_sys,
    input wire logic      srst,
    // Port, events and outputs
    input wire logic      ppp_sel,
    input wire logic      ppp_wr,
    input wire logic      ppp_rd,
    input wire sie_addr_t ppp_addr,
    input wire sie_word_t ppp_wdata,
    input wire sie_word_t ppp_rdata,
    input wire logic      seq_start,
    input wire logic      seq_done,
    input wire logic      seq_status,
    input wire logic      irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    sequence en_wr(sie_word_t d);
        ppp_sel && ppp_wr && ppp_addr == ADDR_ENABLE && ppp_wdata == d;
    endsequence
    sequence en_rd;
        ppp_sel && ppp_rd && ppp_addr == ADDR_ENABLE;
    endsequence
    a_reset_clear: assert property ($fell(srst) |-> !irq && !seq_status && ppp_rdata == 0)
        else $error("outputs not clear after reset");
    a_reserved_zero: assert property ((ppp_rdata & 16'he0f8) == 0)
        else $error("reserved bits read nonzero");
    a_mask_readback: assert property (en_wr(16'hffff) ##[1:2] en_rd ##1 !ppp_rd |=>
        ppp_rdata == ENABLE_WMASK) else $error("enable readback wrong");
    a_enable_off: assert property (en_wr(WORD_ZERO) |-> ##2 !irq)
        else $error("irq with all enables clear");
    a_seq_set: assert property (seq_done |=> seq_status)
        else $error("seq status not set");
    a_seq_clear: assert property (seq_start && !seq_done |=> !seq_status)
        else $error("seq status not cleared");
    a_seq_hold: assert property (!seq_start && !seq_done |=> $stable(seq_status))
        else $error("seq status changed unprompted");
    a_rdata_stands: assert property (!ppp_rd ##1 !ppp_rd |=> $stable(ppp_rdata))
        else $error("read data changed without read");
endmodule
bind sie_top sie_asserts i_sie_asserts (.clk_sys, .srst, .ppp_sel, .ppp_wr, .ppp_rd,
    .ppp_addr, .ppp_wdata, .ppp_rdata, .seq_start, .seq_done, .seq_status, .irq);

// >>> tb/sie_host.sv
// Host processor model on the parallel processor port
`timescale 1ns/10ps
module sie_host
    import sie_pkg::*;
(
    // Clock
    input  wire logic      clk_sys,
    // Port
    output logic           ppp_sel,
    output logic           ppp_wr,
    output logic           ppp_rd,
    output sie_addr_t      ppp_addr,
    output sie_word_t      ppp_wdata,
    input  wire sie_word_t ppp_rdata
);
    initial begin
        ppp_sel = 1'b0;
        ppp_wr = 1'b0;
        ppp_rd = 1'b0;
        ppp_addr = 8'h55;
        ppp_wdata = 16'h5a5a;
    end
    // Single word write; released lines show the inverse
    task wr(input sie_addr_t a, input sie_word_t d);
        @(negedge clk_sys);
        {ppp_sel, ppp_wr, ppp_addr, ppp_wdata} = {2'b11, a, d};
        @(negedge clk_sys);
        {ppp_sel, ppp_wr, ppp_addr, ppp_wdata} = {2'b00, ~a, ~d};
    endtask
    task rd(input sie_addr_t a, output sie_word_t d);
        @(negedge clk_sys);
        {ppp_sel, ppp_rd, ppp_addr} = {2'b11, a};
        @(negedge clk_sys);
        {ppp_sel, ppp_rd, ppp_addr} = {2'b00, ~a};
        @(negedge clk_sys);
        d = ppp_rdata;
    endtask
endmodule

// >>> tb/test_scan_master_interrupt_enable.sv
// Testbench for the interrupt enable block
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
    $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module test_scan_master_interrupt_enable;
    import sie_pkg::*;
    logic      clk_sys, srst, ppp_sel, ppp_wr, ppp_rd, seq_start, seq_done, seq_status, irq;
    sie_addr_t ppp_addr;
    sie_word_t ppp_wdata, ppp_rdata, rdata;
    sie_cnt_t  cap_count, out_count;
    sie_vec_t  vec_done;
    int        checks = 0, n_mismatch = 0;
    sie_word_t en_t [11] = '{16'h1000, 16'h1000, 16'h0800, 16'h0400, 16'h0200, 16'h0200,
                             16'h0003, 16'h0002, 16'h0103, 16'h0005, 16'h0004};
    sie_cnt_t  cap_t [11] = '{7'h38, 7'h39, 7'h00, 7'h3c, 7'h3c, 7'h3c, 7'h3c, 7'h3c,
                              7'h3c, 7'h3c, 7'h3c};
    sie_cnt_t  out_t [11] = '{7'h00, 7'h00, 7'h00, 7'h70, 7'h38, 7'h37, 7'h00, 7'h00,
                              7'h00, 7'h00, 7'h00};
    sie_vec_t  vec_t [11] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h3, 3'h5, 3'h4};
    logic [10:0] exp_t = 11'h45d;
    sie_top i_sie_top (.clk_sys, .srst, .ppp_sel, .ppp_wr, .ppp_rd, .ppp_addr, .ppp_wdata,
        .ppp_rdata, .cap_count, .out_count, .seq_start, .seq_done, .vec_done, .seq_status, .irq);
    sie_host i_sie_host (.clk_sys, .ppp_sel, .ppp_wr, .ppp_rd, .ppp_addr, .ppp_wdata, .ppp_rdata);
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (5000) @(posedge clk_sys);
        n_mismatch++;
        tally_and_finish;
    end
    initial begin
        {srst, seq_start, seq_done, vec_done, cap_count, out_count} = {3'b100, 3'h0, 7'h3c, 7'h00};
        repeat (4) @(posedge clk_sys);
        @(negedge clk_sys) srst = 1'b0;
        i_sie_host.rd(ADDR_ENABLE, rdata);
        `CHK("enable reset", ENABLE_RESET, rdata)
        i_sie_host.wr(ADDR_ENABLE, 16'hffff);
        i_sie_host.rd(ADDR_ENABLE, rdata);
        `CHK("enable mask", ENABLE_WMASK, rdata)
        i_sie_host.wr(ADDR_ENABLE, WORD_ZERO);
        i_sie_host.wr(8'h7f, 16'hffff);
        i_sie_host.rd(8'h7f, rdata);
        `CHK("unmapped read", WORD_ZERO, rdata)
        i_sie_host.rd(ADDR_ENABLE, rdata);
        `CHK("enable kept", WORD_ZERO, rdata)
        $display("test registers done");
        for (int i = 0; i < 11; i++) begin
            @(negedge clk_sys) seq_start = 1'b1;
            @(negedge clk_sys) {seq_start, vec_done} = {1'b0, vec_t[i]};
            @(negedge clk_sys) {vec_done, cap_count, out_count} = {3'h0, cap_t[i], out_t[i]};
            i_sie_host.wr(ADDR_ENABLE, en_t[i]);
            repeat (4) @(negedge clk_sys);
            `CHK("source irq", exp_t[i], irq)
            i_sie_host.wr(ADDR_ENABLE, WORD_ZERO);
            repeat (3) @(negedge clk_sys);
            `CHK("masked irq", 1'b0, irq)
        end
        $display("test sources done");
        @(negedge clk_sys) seq_done = 1'b1;
        @(negedge clk_sys) seq_done = 1'b0;
        `CHK("seq set", 1'b1, seq_status)
        i_sie_host.rd(ADDR_STATUS, rdata);
        `CHK("status view", 16'h0104, rdata)
        i_sie_host.wr(ADDR_ENABLE, 16'h0100);
        repeat (3) @(negedge clk_sys);
        `CHK("seq irq", 1'b1, irq)
        @(negedge clk_sys) seq_start = 1'b1;
        @(negedge clk_sys) seq_start = 1'b0;
        `CHK("seq clear", 1'b0, seq_status)
        repeat (3) @(negedge clk_sys);
        `CHK("seq irq off", 1'b0, irq)
        @(negedge clk_sys) seq_done = 1'b1;
        @(negedge clk_sys) {seq_done, srst} = 2'b01;
        repeat (2) @(negedge clk_sys);
        srst = 1'b0;
        `CHK("irq after reset", 1'b0, irq)
        `CHK("seq after reset", 1'b0, seq_status)
        i_sie_host.rd(ADDR_ENABLE, rdata);
        `CHK("enable after reset", ENABLE_RESET, rdata)
        $display("test sequencer done");
        tally_and_finish;
    end
endmodule
